/* design/serial_pkg.sv */
// Constants, register map and encodings shared by the serial port files.
package serial_pkg;
	localparam int ADDR_W = 16;
	localparam int DATA_W = 16;
	localparam int DIV_W = 15;
	localparam logic [ADDR_W-1:0] ADDR_RX_BUF = 16'h1fb8;
	localparam logic [ADDR_W-1:0] ADDR_STATUS = 16'h1fb9;
	localparam logic [ADDR_W-1:0] ADDR_TX_BUF = 16'h1fba;
	localparam logic [ADDR_W-1:0] ADDR_CONTROL = 16'h1fbb;
	localparam logic [ADDR_W-1:0] ADDR_DIVISOR = 16'h1fbc;
	localparam logic [ADDR_W-1:0] ADDR_P2_FSEL = 16'h1fc9;
	localparam logic [ADDR_W-1:0] ADDR_P2_DIR = 16'h1fcb;
	localparam logic [ADDR_W-1:0] ADDR_P2_LATCH = 16'h1fcd;
	// Control fields
	localparam int CTL_MODE_LO = 0;
	localparam int CTL_MODE_HI = 1;
	localparam int CTL_PEN = 2;
	localparam int CTL_REN = 3;
	localparam int CTL_TB8 = 4;
	localparam logic [7:0] CTL_WRITE_MASK = 8'h1f;
	// Status fields
	localparam int ST_OVERRUN = 2;
	localparam int ST_TXE = 3;
	localparam int ST_FRAMING = 4;
	localparam int ST_TXDONE = 5;
	localparam int ST_RXDONE = 6;
	localparam int ST_NINTH = 7;
	// Divisor source select bit
	localparam int DIV_SRC_BIT = 15;
	localparam logic [15:0] DIV_READ_VALUE = 16'hffff;
	// Port 2 pin numbers used by the serial unit
	localparam int PIN_TXD = 0;
	localparam int PIN_RXD = 1;
	// Reset values
	localparam logic [7:0] RST_CONTROL = 8'h00;
	localparam logic [15:0] RST_DIVISOR = 16'h0000;
	localparam logic [7:0] RST_P2_FSEL = 8'h80;
	localparam logic [7:0] RST_P2_DIR = 8'h7f;
	localparam logic [7:0] RST_P2_LATCH = 8'h7f;
	// Timing: baud ticks per async bit and the mid-bit sample tick
	localparam logic [2:0] TICK_LAST = 3'h7;
	localparam logic [2:0] SAMPLE_POINT = 3'h4;
	localparam logic [3:0] SYNC_BITS = 4'h8;
	localparam logic [3:0] FRAME_LEN_8 = 4'ha;
	localparam logic [3:0] FRAME_LEN_9 = 4'hb;
	localparam logic [3:0] RX_DATA_8 = 4'h8;
	localparam logic [3:0] RX_DATA_9 = 4'h9;
	// External rate pin ceiling against the 40 MHz sampling clock
	localparam int CLK_KHZ = 40000;
	localparam int EXT_RATE_MAX_KHZ = 4000;
	localparam int EXT_MIN_CYCLES = (CLK_KHZ + EXT_RATE_MAX_KHZ - 1) / EXT_RATE_MAX_KHZ;

	typedef enum logic [1:0] {
		MODE_SYNC = 2'b00,
		MODE_ASYNC8 = 2'b01,
		MODE_ASYNC9 = 2'b10,
		MODE_ASYNC9P = 2'b11
	} mode_e;

	typedef enum logic [1:0] {
		RX_IDLE = 2'b00,
		RX_START = 2'b01,
		RX_DATA = 2'b10,
		RX_STOP = 2'b11
	} rx_state_e;

	typedef enum logic {
		TX_IDLE = 1'b0,
		TX_SHIFT = 1'b1
	} tx_state_e;
endpackage : serial_pkg

/* design/baud_if.sv */
// Interface between the serial core and its baud generator.
`timescale 1ns/1ps
interface baud_if;
	logic [serial_pkg::DIV_W-1:0] divisor;
	logic use_crystal;
	logic ext_rate;
	logic tick;
	modport gen (input divisor, input use_crystal, input ext_rate, output tick);
	modport user (output divisor, output use_crystal, output ext_rate, input tick);
endinterface : baud_if

/* design/pin_sync.sv */
// Two-flop synchronisers for asynchronous pin inputs.
`timescale 1ns/1ps
module pin_sync #(
	parameter int WIDTH = 2
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	// Pins in, synchronised out
	input wire logic [WIDTH-1:0] async_i,
	output logic [WIDTH-1:0] sync_o
);
	for (genvar g = 0; g < WIDTH; g++) begin : g_bit
		logic meta_q;
		logic stable_q;
		always_ff @(posedge clk_i or negedge rst_n_i) begin
			if (!rst_n_i) begin
				meta_q <= 1'b1;
				stable_q <= 1'b1;
			end else begin
				meta_q <= async_i[g];
				stable_q <= meta_q;
			end
		end
		assign sync_o[g] = stable_q;
	end
endmodule : pin_sync

/* design/baud_gen.sv */
// Baud tick generator: 15-bit reload divider on crystal or external rate clock.
`timescale 1ns/1ps
module baud_gen (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	// Divisor and tick
	baud_if.gen bus
);
	import serial_pkg::*;
	logic prev_q;
	logic [DIV_W-1:0] cnt_q;
	logic tick_q;
	wire ext_edge = bus.ext_rate & ~prev_q;
	// External pin is used as-is, one count per rising edge, no prescaler
	wire src_en = bus.use_crystal | ext_edge;
	wire wrap = src_en & (cnt_q == '0);

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			prev_q <= 1'b1;
			cnt_q <= '0;
			tick_q <= 1'b0;
		end else begin
			prev_q <= bus.ext_rate;
			tick_q <= wrap;
			if (wrap) begin
				cnt_q <= bus.divisor;
			end else if (src_en) begin
				cnt_q <= cnt_q - 1'b1;
			end
		end
	end
	assign bus.tick = tick_q;
endmodule : baud_gen

/* design/serial_port.sv */
// Serial port core: registers, transmitter, receiver and port 2 pin control.
`timescale 1ns/1ps
module serial_port (
	// Clock and reset
	input wire logic ref_clk_i,
	input wire logic arst_n_i,
	// Register bus
	input wire logic [serial_pkg::ADDR_W-1:0] addr_i,
	input wire logic [serial_pkg::DATA_W-1:0] wdata_i,
	input wire logic wr_i,
	input wire logic word_i,
	input wire logic rd_i,
	output logic [serial_pkg::DATA_W-1:0] rdata_o,
	// Pins
	input wire logic rxd_pin_i,
	input wire logic ext_rate_pin_i,
	output logic txd_o,
	output logic txd_oe_o,
	output logic rxd_o,
	output logic rxd_oe_o,
	// Interrupt requests to the core
	output logic rx_irq_o,
	output logic tx_irq_o
);
	import serial_pkg::*;

	baud_if baud ();
	logic [1:0] pins_s;
	logic rxd_s;

	pin_sync #(.WIDTH(2)) u_sync (
		.clk_i(ref_clk_i),
		.rst_n_i(arst_n_i),
		.async_i({ext_rate_pin_i, rxd_pin_i}),
		.sync_o(pins_s)
	);
	assign rxd_s = pins_s[0];

	baud_gen u_baud (
		.clk_i(ref_clk_i),
		.rst_n_i(arst_n_i),
		.bus(baud.gen)
	);

	// Register state
	logic [7:0] ctl_q, ctl_d;
	logic [15:0] div_q;
	logic [7:0] fsel_q, dir_q, latch_q;
	logic ri_q, ti_q, fe_q, ovr_q, rpe_q, rb8_q, unread_q;
	logic [7:0] rxbuf_q;
	logic [DATA_W-1:0] rdata_q;

	// Bus decode
	wire wr_ctl = wr_i & (addr_i == ADDR_CONTROL);
	wire wr_tx = wr_i & (addr_i == ADDR_TX_BUF);
	wire wr_div = wr_i & word_i & (addr_i == ADDR_DIVISOR);
	wire wr_fsel = wr_i & (addr_i == ADDR_P2_FSEL);
	wire wr_dir = wr_i & (addr_i == ADDR_P2_DIR);
	wire wr_latch = wr_i & (addr_i == ADDR_P2_LATCH);
	wire rd_status = rd_i & (addr_i == ADDR_STATUS);
	wire rd_rxbuf = rd_i & (addr_i == ADDR_RX_BUF);

	wire [1:0] mode_bits = {ctl_q[CTL_MODE_HI], ctl_q[CTL_MODE_LO]};
	wire mode_e mode = mode_e'(mode_bits);
	wire is_sync = (mode == MODE_SYNC);
	wire is_nine = (mode == MODE_ASYNC9) | (mode == MODE_ASYNC9P);
	wire par_on = ctl_q[CTL_PEN] & ((mode == MODE_ASYNC8) | (mode == MODE_ASYNC9P));
	wire ren = ctl_q[CTL_REN];
	wire tick = baud.tick;

	assign baud.divisor = div_q[DIV_W-1:0];
	assign baud.use_crystal = div_q[DIV_SRC_BIT];
	assign baud.ext_rate = pins_s[1];

	// Transmitter
	tx_state_e tx_state_q;
	logic [7:0] hold_q;
	logic hold_full_q;
	logic [10:0] tx_shift_q;
	logic [3:0] tx_cnt_q, tx_len_q;
	logic [2:0] tx_sub_q;
	logic tx_phase_q;

	wire tx_busy = (tx_state_q == TX_SHIFT);
	wire accept_tx = wr_tx & ~hold_full_q;
	// Bit timing runs regardless of activity so a load waits for the next boundary
	wire tx_bb = tick & (tx_sub_q == TICK_LAST);
	wire tx_load = ~tx_busy & hold_full_q & (is_sync ? tick : tx_bb);
	wire tx_step_async = tx_busy & ~is_sync & tx_bb;
	wire tx_step_sync = tx_busy & is_sync & tick & tx_phase_q;
	wire [3:0] tx_cnt_n = tx_cnt_q + 4'h1;
	wire [3:0] tx_stop_idx = tx_len_q - 4'h1;
	wire ti_set = (tx_step_async & (tx_cnt_n == tx_stop_idx)) |
		(tx_step_sync & (tx_cnt_n == SYNC_BITS));
	wire tx_end = (tx_step_async & (tx_cnt_n == tx_len_q)) | (tx_step_sync & (tx_cnt_n == SYNC_BITS));
	// Parity bit makes the count of ones in the covered bits even
	wire par7 = ^hold_q[6:0];
	wire par8 = ^hold_q;
	wire bit7 = (par_on & ~is_nine) ? par7 : hold_q[7];
	wire ninth = par_on ? par8 : ctl_q[CTL_TB8];
	wire [10:0] frame_async = is_nine ? {1'b1, ninth, bit7, hold_q[6:0], 1'b0}
		: {2'b11, bit7, hold_q[6:0], 1'b0};
	wire [10:0] frame_sync = {3'b111, hold_q};

	always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			tx_sub_q <= '0;
		end else if (tick) begin
			tx_sub_q <= tx_sub_q + 3'h1;
		end
	end

	always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			hold_q <= '0;
			hold_full_q <= 1'b0;
		end else begin
			if (accept_tx) begin
				hold_q <= wdata_i[7:0];
			end
			hold_full_q <= accept_tx | (hold_full_q & ~tx_load);
		end
	end

	always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			tx_state_q <= TX_IDLE;
			tx_shift_q <= '1;
			tx_cnt_q <= '0;
			tx_len_q <= FRAME_LEN_8;
			tx_phase_q <= 1'b1;
		end else if (tx_load) begin
			tx_state_q <= TX_SHIFT;
			tx_shift_q <= is_sync ? frame_sync : frame_async;
			tx_len_q <= is_nine ? FRAME_LEN_9 : FRAME_LEN_8;
			tx_cnt_q <= '0;
			tx_phase_q <= 1'b0;
		end else if (tx_step_async | tx_step_sync) begin
			tx_shift_q <= {1'b1, tx_shift_q[10:1]};
			tx_cnt_q <= tx_cnt_n;
			tx_phase_q <= 1'b0;
			if (tx_end) begin
				tx_state_q <= TX_IDLE;
				tx_phase_q <= 1'b1;
			end
		end else if (tx_busy & is_sync & tick) begin
			tx_phase_q <= 1'b1;
		end
	end

	// Receiver
	rx_state_e rx_state_q;
	logic [2:0] rx_sub_q;
	logic [3:0] rx_cnt_q;
	logic [8:0] rx_shift_q;
	logic rx_prev_q;
	logic rx_phase_q;

	wire rx_idle = (rx_state_q == RX_IDLE);
	wire start_edge = rx_idle & ren & ~is_sync & rx_prev_q & ~rxd_s;
	wire ren_rise = wr_ctl & wdata_i[CTL_REN] & ~ren;
	wire ri_cleared = rd_status & ri_q & ren;
	wire sync_start = rx_idle & is_sync & ~tx_busy & (ren_rise | ri_cleared);
	wire samp = tick & (rx_sub_q == SAMPLE_POINT);
	wire [8:0] rx_next = {rxd_s, rx_shift_q[8:1]};
	wire [3:0] rx_cnt_n = rx_cnt_q + 4'h1;
	wire [3:0] rx_nbits = is_nine ? RX_DATA_9 : RX_DATA_8;
	wire async_last = (rx_state_q == RX_DATA) & ~is_sync & samp & (rx_cnt_n == rx_nbits);
	wire sync_samp = (rx_state_q == RX_DATA) & is_sync & tick & ~rx_phase_q;
	wire sync_last = sync_samp & (rx_cnt_n == SYNC_BITS);
	wire [7:0] rx_byte = is_nine ? rx_next[7:0] : rx_next[8:1];
	wire rx_bad_par = par_on & (is_nine ? (^rx_next) : (^rx_next[8:1]));
	wire rx_keep = (mode != MODE_ASYNC9) | rx_next[8];
	wire rx_load = (async_last & rx_keep) | sync_last;
	wire fe_set = (rx_state_q == RX_STOP) & samp & ~rxd_s;

	always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			rx_state_q <= RX_IDLE;
			rx_sub_q <= '0;
			rx_cnt_q <= '0;
			rx_shift_q <= '0;
			rx_prev_q <= 1'b1;
			rx_phase_q <= 1'b1;
		end else begin
			rx_prev_q <= rxd_s;
			if (tick & ~rx_idle) begin
				rx_sub_q <= rx_sub_q + 3'h1;
			end
			// A control write that raises the enable must reach the sync start below
			if (~ren & ~sync_start) begin
				rx_state_q <= RX_IDLE;
				rx_phase_q <= 1'b1;
			end else if (start_edge) begin
				rx_state_q <= RX_START;
				rx_sub_q <= '0;
			end else if (sync_start) begin
				rx_state_q <= RX_DATA;
				rx_cnt_q <= '0;
				rx_phase_q <= 1'b0;
			end else if (is_sync & (rx_state_q == RX_DATA) & tick) begin
				rx_phase_q <= ~rx_phase_q;
				if (sync_samp) begin
					rx_shift_q <= rx_next;
					rx_cnt_q <= rx_cnt_n;
				end
				if (rx_phase_q) begin
					rx_phase_q <= 1'b0;
				end
				if (sync_last) begin
					rx_state_q <= RX_IDLE;
				end
			end else if (samp) begin
				case (rx_state_q)
					RX_START: begin
						rx_state_q <= rxd_s ? RX_IDLE : RX_DATA;
						rx_cnt_q <= '0;
					end
					RX_DATA: begin
						rx_shift_q <= rx_next;
						rx_cnt_q <= rx_cnt_n;
						if (async_last | (rx_cnt_n == rx_nbits)) begin
							rx_state_q <= RX_STOP;
						end
					end
					RX_STOP: begin
						rx_state_q <= RX_IDLE;
					end
					default: begin
						rx_state_q <= RX_IDLE;
					end
				endcase
			end
		end
	end

	// Receive buffer: newest byte always wins
	always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			rxbuf_q <= '0;
		end else if (rx_load) begin
			rxbuf_q <= rx_byte;
		end
	end

	// Flags: a set in the same cycle as the clearing read wins
	always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			ri_q <= 1'b0;
			ti_q <= 1'b0;
			fe_q <= 1'b0;
			ovr_q <= 1'b0;
			rpe_q <= 1'b0;
			rb8_q <= 1'b0;
			unread_q <= 1'b0;
		end else begin
			ri_q <= rx_load | (ri_q & ~rd_status);
			ti_q <= ti_set | (ti_q & ~rd_status);
			fe_q <= fe_set | (fe_q & ~rd_status);
			ovr_q <= (rx_load & unread_q) | (ovr_q & ~rd_status);
			rpe_q <= (async_last & rx_bad_par) | (rpe_q & ~rd_status);
			unread_q <= rx_load | (unread_q & ~rd_rxbuf);
			if (async_last & rx_keep & is_nine) begin
				rb8_q <= rx_next[8];
			end
		end
	end

	// Control and port 2 registers
	always_comb begin
		ctl_d = ctl_q;
		if (ti_set & is_nine) begin
			ctl_d[CTL_TB8] = 1'b0;
		end
		if (wr_ctl) begin
			ctl_d = wdata_i[7:0] & CTL_WRITE_MASK;
		end
	end

	always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			ctl_q <= RST_CONTROL;
			div_q <= RST_DIVISOR;
			fsel_q <= RST_P2_FSEL;
			dir_q <= RST_P2_DIR;
			latch_q <= RST_P2_LATCH;
		end else begin
			ctl_q <= ctl_d;
			if (wr_div) begin
				div_q <= wdata_i;
			end
			if (wr_fsel) begin
				fsel_q <= wdata_i[7:0];
			end
			if (wr_dir) begin
				dir_q <= wdata_i[7:0];
			end
			if (wr_latch) begin
				latch_q <= wdata_i[7:0];
			end
		end
	end

	// Read data
	wire transmit_empty_flag = ~hold_full_q & ~tx_busy;
	wire bit7_st = par_on ? rpe_q : rb8_q;
	wire [7:0] status = {bit7_st, ri_q, ti_q, fe_q, transmit_empty_flag, ovr_q, 2'b00};
	wire [DATA_W-1:0] rdata_d =
		(addr_i == ADDR_RX_BUF) ? {8'h00, rxbuf_q} :
		(addr_i == ADDR_STATUS) ? {8'h00, status} :
		(addr_i == ADDR_CONTROL) ? {8'h00, ctl_q} :
		(addr_i == ADDR_DIVISOR) ? DIV_READ_VALUE :
		(addr_i == ADDR_P2_FSEL) ? {8'h00, fsel_q} :
		(addr_i == ADDR_P2_DIR) ? {8'h00, dir_q} :
		(addr_i == ADDR_P2_LATCH) ? {8'h00, latch_q} : 16'h0000;

	// Pin drive: shift clock of either direction idles high
	wire rx_sync_act = is_sync & (rx_state_q == RX_DATA);
	wire sclk = (tx_busy ? tx_phase_q : 1'b1) & (rx_sync_act ? rx_phase_q : 1'b1);
	wire txd_line = is_sync ? sclk : (tx_busy ? tx_shift_q[0] : 1'b1);
	// Serial pin 0 is push-pull when its direction bit is clear
	wire txd_d = fsel_q[PIN_TXD] ? txd_line : latch_q[PIN_TXD];
	wire txd_oe_d = ~dir_q[PIN_TXD] | (~fsel_q[PIN_TXD] & ~latch_q[PIN_TXD]);
	// Receive pin is open drain when its function select bit is set, pulled low only for a zero data bit in sync transmit
	wire rxd_low_serial = is_sync & tx_busy & ~tx_shift_q[0];
	wire rxd_oe_d = fsel_q[PIN_RXD] ? rxd_low_serial : (~dir_q[PIN_RXD] | ~latch_q[PIN_RXD]);
	wire rxd_d = fsel_q[PIN_RXD] ? 1'b0 : latch_q[PIN_RXD];

	always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			rdata_q <= '0;
			txd_o <= 1'b1;
			txd_oe_o <= 1'b0;
			rxd_o <= 1'b1;
			rxd_oe_o <= 1'b0;
			rx_irq_o <= 1'b0;
			tx_irq_o <= 1'b0;
		end else begin
			if (rd_i) begin
				rdata_q <= rdata_d;
			end
			txd_o <= txd_d;
			txd_oe_o <= txd_oe_d;
			rxd_o <= rxd_d;
			rxd_oe_o <= rxd_oe_d;
			rx_irq_o <= rx_load;
			tx_irq_o <= ti_set;
		end
	end
	assign rdata_o = rdata_q;
endmodule : serial_port

/* dv/serial_port_monitor.sv */
// Port-level checker for the serial port, bound to its top module.
`timescale 1ns/1ps
module serial_port_monitor (
	// Clock and reset
	input wire logic ref_clk_i,
	input wire logic arst_n_i,
	// Register bus
	input wire logic [serial_pkg::ADDR_W-1:0] addr_i,
	input wire logic [serial_pkg::DATA_W-1:0] wdata_i,
	input wire logic wr_i,
	input wire logic word_i,
	input wire logic rd_i,
	input wire logic [serial_pkg::DATA_W-1:0] rdata_o,
	// Pins and requests
	input wire logic rxd_pin_i,
	input wire logic ext_rate_pin_i,
	input wire logic txd_o,
	input wire logic txd_oe_o,
	input wire logic rxd_o,
	input wire logic rxd_oe_o,
	input wire logic rx_irq_o,
	input wire logic tx_irq_o
);
	import serial_pkg::*;
	// Shadows of software writes; the hardware clear of the ninth bit is not tracked
	logic [7:0] ctl_q;
	logic [7:0] fsel_q;
	logic [7:0] dir_q;
	wire rd_status = rd_i && addr_i == ADDR_STATUS;
	always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			ctl_q <= RST_CONTROL;
			fsel_q <= RST_P2_FSEL;
			dir_q <= RST_P2_DIR;
		end else if (wr_i) begin
			if (addr_i == ADDR_CONTROL) ctl_q <= wdata_i[7:0];
			if (addr_i == ADDR_P2_FSEL) fsel_q <= wdata_i[7:0];
			if (addr_i == ADDR_P2_DIR) dir_q <= wdata_i[7:0];
		end
	end
	default clocking cb @(posedge ref_clk_i);
	endclocking
	default disable iff (!arst_n_i);
	a_divisor_reads_ones: assert property (
		rd_i && addr_i == ADDR_DIVISOR |=> rdata_o == DIV_READ_VALUE)
		else $error("divisor read not all ones");
	a_status_clears: assert property (
		rd_status ##2 (rd_status && !rx_irq_o && !tx_irq_o && !$past(rx_irq_o) && !$past(tx_irq_o))
		|=> rdata_o[ST_RXDONE] == 1'b0 && rdata_o[ST_TXDONE] == 1'b0)
		else $error("done flags survived a status read");
	a_tx_irq_pulse: assert property (
		tx_irq_o |=> !tx_irq_o)
		else $error("transmit request longer than one cycle");
	a_rx_needs_enable: assert property (
		rx_irq_o |-> ctl_q[CTL_REN] || $past(ctl_q[CTL_REN]))
		else $error("receive request with receiver off");
	a_control_readback: assert property (
		rd_i && addr_i == ADDR_CONTROL |=> rdata_o[15:5] == 11'h000 && rdata_o[3:0] == $past(ctl_q[3:0]))
		else $error("control read differs from written mode bits");
	a_txe_clears: assert property (
		wr_i && addr_i == ADDR_TX_BUF ##2 rd_status |=> !rdata_o[ST_TXE])
		else $error("empty flag still set after buffer write");
	a_txd_push_pull: assert property (
		(fsel_q[PIN_TXD] && !dir_q[PIN_TXD]) [*3] |-> txd_oe_o)
		else $error("transmit pin not driven");
	a_rxd_async_input: assert property (
		(fsel_q[PIN_RXD] && ctl_q[1:0] != 2'b00) [*3] |-> !rxd_oe_o)
		else $error("data pin driven outside shift mode");
	a_rxd_open_drain: assert property (
		fsel_q[PIN_RXD] && $past(fsel_q[PIN_RXD]) && rxd_oe_o |-> !rxd_o)
		else $error("data pin driven high");
endmodule : serial_port_monitor

bind serial_port serial_port_monitor u_monitor (
	.ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
	.wr_i(wr_i), .word_i(word_i), .rd_i(rd_i), .rdata_o(rdata_o), .rxd_pin_i(rxd_pin_i),
	.ext_rate_pin_i(ext_rate_pin_i), .txd_o(txd_o), .txd_oe_o(txd_oe_o), .rxd_o(rxd_o),
	.rxd_oe_o(rxd_oe_o), .rx_irq_o(rx_irq_o), .tx_irq_o(tx_irq_o)
);

/* dv/remote_uart.sv */
// Far-end serial device: frame sender, frame receiver and shift-register sampler.
`timescale 1ns/1ps
module remote_uart #(
	parameter int BIT_CYC = 8
) (
	// Clock
	input wire logic clk_i,
	// Lines
	input wire logic tx_line_i,
	input wire logic data_line_i,
	output logic drive_o
);
	// High means released: the line's pull-up holds it at one
	initial drive_o = 1'b1;
	task automatic send(input logic [8:0] data, input int nbits, input logic stop);
		@(posedge clk_i);
		drive_o <= 1'b0;
		repeat (BIT_CYC) @(posedge clk_i);
		for (int i = 0; i < nbits; i++) begin
			drive_o <= data[i];
			repeat (BIT_CYC) @(posedge clk_i);
		end
		drive_o <= stop;
		repeat (BIT_CYC) @(posedge clk_i);
		drive_o <= 1'b1;
		repeat (2 * BIT_CYC) @(posedge clk_i);
	endtask : send
	// Sampling on the falling clock edge keeps clear of the registered pin updates
	task automatic recv(input int nbits, output logic [8:0] data, output logic ok);
		int n;
		data = 9'h000;
		n = 0;
		while (tx_line_i !== 1'b0 && n < 3000) begin
			@(negedge clk_i);
			n++;
		end
		repeat (BIT_CYC / 2) @(negedge clk_i);
		for (int i = 0; i < nbits; i++) begin
			repeat (BIT_CYC) @(negedge clk_i);
			data[i] = tx_line_i;
		end
		repeat (BIT_CYC) @(negedge clk_i);
		ok = n < 3000 && tx_line_i === 1'b1;
	endtask : recv
	task automatic shift_in(output logic [7:0] data, output int pulses);
		logic prev;
		prev = 1'b1;
		pulses = 0;
		data = 8'h00;
		repeat (200) begin
			@(negedge clk_i);
			if (tx_line_i === 1'b1 && !prev && pulses < 8) data[pulses] = data_line_i;
			if (tx_line_i === 1'b1 && !prev) pulses++;
			prev = tx_line_i;
		end
	endtask : shift_in
endmodule : remote_uart

/* dv/test_serial_port.sv */
// Self-checking bench for the serial port with a far-end model.
`timescale 1ns/1ps
module test_serial_port;
	import serial_pkg::*;
	localparam int DLY = 2;
	localparam int LIMIT = 20000;
	localparam logic [15:0] FR_CTL [3] = '{16'h0005, 16'h0006, 16'h0013};
	localparam logic [15:0] FR_DAT [3] = '{16'h0007, 16'h0001, 16'h005a};
	localparam int FR_BITS [3] = '{8, 9, 9};
	localparam logic [15:0] FR_EXP [3] = '{16'h0287, 16'h0201, 16'h035a};
	logic ref_clk_i, arst_n_i, wr_i, word_i, rd_i, ok, far_drive, ext_pin;
	logic [ADDR_W-1:0] addr_i;
	logic [DATA_W-1:0] wdata_i, rdata_o;
	logic txd_o, txd_oe_o, rxd_o, rxd_oe_o, rx_irq_o, tx_irq_o;
	logic [8:0] fr;
	logic [7:0] sb;
	int err_total, checks_done, cycles, np;
	// Open-drain data pin with pull-up: low only when someone pulls it low
	wire rxd_line = (rxd_oe_o && !rxd_o) ? 1'b0 : far_drive;
	wire txd_line = txd_oe_o ? txd_o : 1'b1;
	serial_port dut (.ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
		.wr_i(wr_i), .word_i(word_i), .rd_i(rd_i), .rdata_o(rdata_o), .rxd_pin_i(rxd_line),
		.ext_rate_pin_i(ext_pin), .txd_o(txd_o), .txd_oe_o(txd_oe_o), .rxd_o(rxd_o),
		.rxd_oe_o(rxd_oe_o), .rx_irq_o(rx_irq_o), .tx_irq_o(tx_irq_o));
	remote_uart #(.BIT_CYC(8)) far (.clk_i(ref_clk_i), .tx_line_i(txd_line), .data_line_i(rxd_line),
		.drive_o(far_drive));
	initial begin
		ref_clk_i = 1'b0;
		forever #12.5 ref_clk_i = ~ref_clk_i;
	end
	always @(posedge ref_clk_i) begin
		cycles++;
		if (cycles >= LIMIT) begin
			err_total++;
			tally_and_finish();
		end
	end
	task automatic tally_and_finish;
		$display("Checks made: %0d, mismatches: %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : tally_and_finish
	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		checks_done++;
		if (seen !== exp) begin
			err_total++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic bus(input logic w, input logic [15:0] a, input logic [15:0] d, output logic [15:0] r);
		@(posedge ref_clk_i);
		#DLY;
		wr_i = w;
		rd_i = !w;
		addr_i = a;
		wdata_i = d;
		word_i = a == ADDR_DIVISOR;
		@(posedge ref_clk_i);
		#DLY;
		wr_i = 1'b0;
		rd_i = 1'b0;
		r = rdata_o;
	endtask : bus
	task automatic wr(input logic [15:0] a, input logic [15:0] d);
		logic [15:0] r;
		bus(1'b1, a, d, r);
	endtask : wr
	task automatic rdchk(input string what, input logic [15:0] a, input logic [15:0] m, input logic [15:0] exp);
		logic [15:0] r;
		bus(1'b0, a, 16'h0000, r);
		check(what, r & m, exp);
	endtask : rdchk
	task automatic wait_irq(input logic rx, input int lim, input logic exp, input string what);
		logic got;
		got = 1'b0;
		for (int n = 0; n < lim && !got; n++) begin
			@(negedge ref_clk_i);
			got = rx ? rx_irq_o === 1'b1 : tx_irq_o === 1'b1;
		end
		check(what, {15'h0000, got}, {15'h0000, exp});
	endtask : wait_irq
	task automatic t_reset_and_setup;
		rdchk("status", ADDR_STATUS, 16'h00ff, 16'h0008);
		rdchk("control", ADDR_CONTROL, 16'hffff, 16'h0000);
		rdchk("fsel", ADDR_P2_FSEL, 16'hffff, 16'h0080);
		wr(ADDR_P2_DIR, 16'h007e);
		wr(ADDR_P2_FSEL, 16'h0083);
		wr(ADDR_DIVISOR, 16'h8000);
		rdchk("divisor", ADDR_DIVISOR, 16'hffff, 16'hffff);
		check("txd enable", {15'h0000, txd_oe_o}, 16'h0001);
		$display("reset and setup test done");
	endtask : t_reset_and_setup
	task automatic t_async_tx;
		wr(ADDR_CONTROL, 16'h0001);
		fork
			begin
				wr(ADDR_TX_BUF, 16'h005a);
				rdchk("txe after write", ADDR_STATUS, 16'h0008, 16'h0000);
				wr(ADDR_TX_BUF, 16'h00c3);
			end
			begin
				far.recv(8, fr, ok);
				check("frame 1", {6'h00, ok, fr}, 16'h025a);
				far.recv(8, fr, ok);
				check("frame 2", {6'h00, ok, fr}, 16'h02c3);
			end
		join
		repeat (8) @(posedge ref_clk_i);
		rdchk("done and empty", ADDR_STATUS, 16'h0028, 16'h0028);
		rdchk("done cleared", ADDR_STATUS, 16'h0020, 16'h0000);
		for (int i = 0; i < 3; i++) begin
			wr(ADDR_CONTROL, FR_CTL[i]);
			fork
				wr(ADDR_TX_BUF, FR_DAT[i]);
				begin
					far.recv(FR_BITS[i], fr, ok);
					check("framed byte", {6'h00, ok, fr}, FR_EXP[i]);
				end
				wait_irq(1'b0, 150, 1'b1, "tx request");
			join
			rdchk("ninth bit cleared", ADDR_CONTROL, 16'h0010, 16'h0000);
		end
		$display("async transmit test done");
	endtask : t_async_tx
	task automatic t_async_rx;
		wr(ADDR_CONTROL, 16'h0009);
		fork
			far.send(9'h03c, 8, 1'b1);
			wait_irq(1'b1, 200, 1'b1, "rx request");
		join
		rdchk("rx done", ADDR_STATUS, 16'h0054, 16'h0040);
		rdchk("rx data", ADDR_RX_BUF, 16'h00ff, 16'h003c);
		far.send(9'h011, 8, 1'b1);
		far.send(9'h022, 8, 1'b1);
		rdchk("overrun", ADDR_STATUS, 16'h0004, 16'h0004);
		rdchk("newest kept", ADDR_RX_BUF, 16'h00ff, 16'h0022);
		far.send(9'h055, 8, 1'b0);
		rdchk("framing", ADDR_STATUS, 16'h0010, 16'h0010);
		wr(ADDR_CONTROL, 16'h000d);
		far.send(9'h007, 8, 1'b1);
		rdchk("parity error", ADDR_STATUS, 16'h0080, 16'h0080);
		wr(ADDR_CONTROL, 16'h000a);
		fork
			far.send(9'h0aa, 9, 1'b1);
			wait_irq(1'b1, 150, 1'b0, "data frame filtered");
		join
		fork
			far.send(9'h1aa, 9, 1'b1);
			wait_irq(1'b1, 150, 1'b1, "address frame");
		join
		rdchk("ninth received", ADDR_STATUS, 16'h0080, 16'h0080);
		rdchk("address data", ADDR_RX_BUF, 16'h00ff, 16'h00aa);
		wr(ADDR_CONTROL, 16'h0001);
		fork
			far.send(9'h0f0, 8, 1'b1);
			wait_irq(1'b1, 150, 1'b0, "receiver off");
		join
		$display("async receive test done");
	endtask : t_async_rx
	task automatic t_sync;
		wr(ADDR_CONTROL, 16'h0000);
		fork
			wr(ADDR_TX_BUF, 16'h0096);
			far.shift_in(sb, np);
			wait_irq(1'b0, 150, 1'b1, "sync tx done");
		join
		check("sync data", {8'h00, sb}, 16'h0096);
		check("sync pulses", 16'(np), 16'h0008);
		fork
			wr(ADDR_CONTROL, 16'h0008);
			wait_irq(1'b1, 150, 1'b1, "sync rx start");
		join
		rdchk("sync rx data", ADDR_RX_BUF, 16'h00ff, 16'h00ff);
		fork
			rdchk("sync rx done", ADDR_STATUS, 16'h0040, 16'h0040);
			wait_irq(1'b1, 150, 1'b1, "sync rx restart");
		join
		// External rate pin as tick source, toggled at its 4 MHz ceiling
		wr(ADDR_DIVISOR, 16'h0000);
		fork
			wr(ADDR_TX_BUF, 16'h003c);
			far.shift_in(sb, np);
			wait_irq(1'b0, 250, 1'b1, "ext rate tx done");
			repeat (40) begin
				repeat (5) @(posedge ref_clk_i);
				#DLY;
				ext_pin = ~ext_pin;
			end
		join
		check("ext rate data", {8'h00, sb}, 16'h003c);
		check("ext rate pulses", 16'(np), 16'h0008);
		$display("sync test done");
	endtask : t_sync
	initial begin
		arst_n_i = 1'b0;
		wr_i = 1'b0;
		rd_i = 1'b0;
		word_i = 1'b0;
		ext_pin = 1'b0;
		addr_i = 16'h0000;
		wdata_i = 16'h0000;
		repeat (12) @(posedge ref_clk_i);
		#DLY;
		arst_n_i = 1'b1;
		t_reset_and_setup();
		t_async_tx();
		t_async_rx();
		t_sync();
		tally_and_finish();
	end
endmodule : test_serial_port
